// File: dqs_pkg.sv
// Purpose: Shared types and constants of the disk request queue scheduler
// Assumes: 16-bit buffer memory words, two words per queue entry
// Notes:   Key field order inside dqs_req_s is the sort order
package dqs_pkg;

  // ****************************************************************
  // Buffer memory and queue layout
  // ****************************************************************
  localparam int MEM_WORDS = 4096;
  localparam int MEM_W     = 16;
  localparam int MEM_AW    = 12;
  localparam int ENT_WORDS = 2;
  localparam int QDEPTH    = 1024;

  // ****************************************************************
  // Request fields and aging
  // ****************************************************************
  localparam int SECT_W = 6;
  localparam int HEAD_W = 4;
  localparam int DRV_W  = 3;
  localparam int CYL_W  = 10;
  localparam int BUMP_W = 4;
  localparam logic [BUMP_W-1:0] BUMP_ZERO = 4'h0;
  localparam logic [BUMP_W-1:0] BUMP_STEP = 4'h1;

  // ****************************************************************
  // Sector image slots
  // ****************************************************************
  localparam int SLOTS  = 8;
  localparam int SLOT_W = 3;

  // Write sorts ahead of read
  typedef enum logic {DQS_WRITE, DQS_READ} dqs_kind_e;

  typedef struct packed {
    dqs_kind_e          kind;
    logic [SECT_W-1:0]  sector;
    logic [HEAD_W-1:0]  head;
    logic [DRV_W-1:0]   drive;
    logic [CYL_W-1:0]   cyl;
  } dqs_req_s;

  typedef struct packed {
    logic [SECT_W-1:0]  sector;
    logic [HEAD_W-1:0]  head;
    logic [DRV_W-1:0]   drive;
    logic [CYL_W-1:0]   cyl;
  } dqs_tag_s;

  typedef struct packed {
    logic [BUMP_W-1:0]  bump;
    dqs_req_s           req;
  } dqs_ent_s;

  typedef logic [ENT_WORDS*MEM_W-1:0] dqs_dword_t;
  localparam int ENT_BITS = $bits(dqs_ent_s);

  typedef enum logic [2:0] {
    DQS_IDLE, DQS_FETCH, DQS_SCAN, DQS_MERGE, DQS_EMIT, DQS_FIN
  } dqs_state_e;

endpackage

// File: dqs_mem.sv
// Purpose: Buffer memory holding the request queue, one write one read port
// Assumes: Read data valid one clock after the read strobe
// Notes:   Array carries no reset; read data register does
`timescale 1ns/1ps
module dqs_mem #(
  parameter int W     = dqs_pkg::MEM_W,
  parameter int DEPTH = dqs_pkg::MEM_WORDS,
  parameter int AW    = dqs_pkg::MEM_AW
) (
  // Clock and reset
  input  wire logic          i_clk,
  input  wire logic          i_rst_n,
  // Write port
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [W-1:0]  i_wdata,
  // Read port
  input  wire logic          i_re,
  input  wire logic [AW-1:0] i_raddr,
  output logic      [W-1:0]  o_rdata
);
  import dqs_pkg::*;

  initial begin
    if (DEPTH > (1 << AW)) $error("dqs_mem: DEPTH exceeds address range");
  end

  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= '0;
    end else if (i_re) begin
      o_rdata <= mem[i_raddr];
    end
  end

  a_addr_range: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_we |-> int'(i_waddr) < DEPTH) // R8
    else $error("buffer write outside memory");
endmodule // dqs_mem

// File: dqs_cache.sv
// Purpose: Tags and recency order of the retained sector images
// Assumes: Fill wins over touch when both arrive together
// Notes:   Ages form a permutation; the oldest slot is the victim
`timescale 1ns/1ps
module dqs_cache #(
  parameter int N  = dqs_pkg::SLOTS,
  parameter int SW = dqs_pkg::SLOT_W
) (
  // Clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  // Lookup
  input  dqs_pkg::dqs_tag_s      i_look,
  output logic                   o_hit,
  output logic [SW-1:0]          o_hit_slot,
  // Recency update on a hit
  input  wire logic              i_touch,
  input  wire logic [SW-1:0]     i_touch_slot,
  // New image retained
  input  wire logic              i_fill,
  input  dqs_pkg::dqs_tag_s      i_fill_tag,
  output logic [SW-1:0]          o_fill_slot
);
  import dqs_pkg::*;

  initial begin
    if (N != (1 << SW)) $error("dqs_cache: N must equal 2**SW");
  end

  typedef struct packed {
    dqs_tag_s [N-1:0]        tag;
    logic     [N-1:0]        vld;
    logic     [N-1:0][SW-1:0] age;
  } dqs_cst_s;

  function automatic dqs_cst_s cst_init();
    dqs_cst_s c;
    c = '0;
    for (int i = 0; i < N; i++) begin
      c.age[i] = SW'(i);
    end
    return c;
  endfunction

  localparam dqs_cst_s CST_RESET = cst_init();

  function automatic dqs_cst_s use_slot(dqs_cst_s c, logic [SW-1:0] k);
    dqs_cst_s r;
    r = c;
    for (int i = 0; i < N; i++) begin
      if (c.age[i] < c.age[k]) r.age[i] = c.age[i] + 1'b1;
    end
    r.age[k] = '0;
    return r;
  endfunction

  dqs_cst_s      s;
  dqs_cst_s      next_s;
  logic          fill_match;
  logic [SW-1:0] oldest;

  always_comb begin
    o_hit       = 1'b0;
    o_hit_slot  = '0;
    fill_match  = 1'b0;
    o_fill_slot = '0;
    oldest      = '0;
    for (int i = 0; i < N; i++) begin
      if (s.vld[i] && s.tag[i] == i_look) begin
        o_hit      = 1'b1;
        o_hit_slot = SW'(i);
      end
      if (s.age[i] == SW'(N - 1)) oldest = SW'(i);
    end
    for (int i = 0; i < N; i++) begin
      if (s.vld[i] && s.tag[i] == i_fill_tag) begin
        fill_match  = 1'b1;
        o_fill_slot = SW'(i);
      end
    end
    if (!fill_match) o_fill_slot = oldest; // R12
    next_s = s;
    if (i_fill) begin
      next_s = use_slot(s, o_fill_slot);
      next_s.tag[o_fill_slot] = i_fill_tag; // R9
      next_s.vld[o_fill_slot] = 1'b1;
    end else if (i_touch) begin
      next_s = use_slot(s, i_touch_slot);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s <= CST_RESET;
    end else begin
      s <= next_s;
    end
  end

  a_victim_oldest: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_fill && !fill_match |-> s.age[o_fill_slot] == SW'(N - 1)) // R12
    else $error("replaced image is not the least recent");

  a_fill_kept: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_fill |=> s.vld[$past(o_fill_slot)] && s.age[$past(o_fill_slot)] == '0
      && s.tag[$past(o_fill_slot)] == $past(i_fill_tag)) // R9
    else $error("retained image tag not stored");
endmodule // dqs_cache

// File: dqs_sched.sv
// Purpose: Aging-sorted disk request queue with sector image bypass
// Assumes: Inputs synchronous to i_clk; limit held steady while busy
// Notes:   Queue rebuilt into the other memory bank on each insert
//
// Function
// R1 - New request starts with bump count zero
// R2 - New request goes behind all saturated requests
// R3 - Sorted insert by type, sector, head, drive, cylinder
// R4 - Writes sort ahead of equal reads
// R5 - Scan moves saturated sorted entries to priority tail
// R6 - Entries behind new request gain one bump
// R7 - Host picks aging threshold per application
// R8 - Queue lives in 4096 x 16 buffer memory
// R9 - Keep tags of eight most recent sectors
// R10 - Read hitting an image is served, not queued
// R11 - Cylinder key compares last
// R12 - Replace least recently used image when full
`timescale 1ns/1ps
module dqs_sched #(
  parameter int QD = dqs_pkg::QDEPTH
) (
  // Clock and reset
  input  wire logic                          i_clk,
  input  wire logic                          i_rst_n,
  // Configuration
  input  wire logic [dqs_pkg::BUMP_W-1:0]    i_bump_limit,
  // Host requests
  input  wire logic                          i_req_valid,
  input  dqs_pkg::dqs_req_s                  i_req,
  output logic                               o_req_ready,
  output logic                               o_hit_valid,
  output logic [dqs_pkg::SLOT_W-1:0]         o_hit_slot,
  // Sequencer side
  input  wire logic                          i_pop,
  output dqs_pkg::dqs_ent_s                  o_head,
  output logic                               o_head_valid,
  input  wire logic                          i_done_valid,
  input  dqs_pkg::dqs_tag_s                  i_done_tag,
  output logic                               o_img_valid,
  output logic [dqs_pkg::SLOT_W-1:0]         o_img_slot
);
  import dqs_pkg::*;

  localparam int IW = $clog2(QD);
  localparam int LW = IW + 1;

  initial begin
    if (QD * ENT_WORDS * 2 > MEM_WORDS || QD != (1 << IW))
      $error("dqs_sched: QD must be a power of two fitting two banks");
  end

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    dqs_state_e        st;
    dqs_state_e        ret;
    logic [1:0]        ph;
    logic              bank;
    logic [LW-1:0]     head_i;
    logic [LW-1:0]     qlen;
    logic [LW-1:0]     q1len;
    logic [LW-1:0]     src_i;
    logic [LW-1:0]     dst_i;
    logic [LW-1:0]     dst_q1;
    dqs_req_s          newreq;
    logic              ins;
    logic [MEM_W-1:0]  hi_buf;
    dqs_ent_s          em0;
    dqs_ent_s          em1;
    logic [1:0]        em_n;
    logic              req_ready;
    logic              hit_valid;
    logic [SLOT_W-1:0] hit_slot;
    dqs_ent_s          head;
    logic              head_valid;
    logic              img_valid;
    logic [SLOT_W-1:0] img_slot;
  } dqs_st_s;

  dqs_st_s           s;
  dqs_st_s           next_s;
  logic              mem_we;
  logic [MEM_AW-1:0] mem_waddr;
  logic [MEM_W-1:0]  mem_wdata;
  logic              mem_re;
  logic [MEM_AW-1:0] mem_raddr;
  logic [MEM_W-1:0]  mem_rdata;
  dqs_dword_t        rd_word;
  dqs_dword_t        em_word;
  dqs_ent_s          rd_ent;
  dqs_ent_s          bumped_ent;
  dqs_ent_s          new_ent;
  logic              c_hit;
  logic [SLOT_W-1:0] c_hit_slot;
  logic              c_touch;
  logic [SLOT_W-1:0] c_fill_slot;
  logic              rd_sat;
  logic              new_first;

  function automatic logic [MEM_AW-1:0] ent_addr(logic bank,
      logic [LW-1:0] idx, logic w);
    return MEM_AW'({bank, idx[IW-1:0], w});
  endfunction

  assign rd_word    = {s.hi_buf, mem_rdata};
  assign rd_ent     = rd_word[ENT_BITS-1:0];
  assign em_word    = dqs_dword_t'(s.em0);
  assign rd_sat     = rd_ent.bump == i_bump_limit;
  assign new_first  = s.newreq < rd_ent.req; // R3 R4 R11
  assign bumped_ent = '{bump: rd_ent.bump + BUMP_STEP, req: rd_ent.req}; // R6
  assign new_ent    = '{bump: BUMP_ZERO, req: s.newreq}; // R1

  // ****************************************************************
  // Submodules
  // ****************************************************************
  dqs_mem u_mem (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_we    (mem_we),
    .i_waddr (mem_waddr),
    .i_wdata (mem_wdata),
    .i_re    (mem_re),
    .i_raddr (mem_raddr),
    .o_rdata (mem_rdata)
  );

  dqs_cache u_cache (
    .i_clk        (i_clk),
    .i_rst_n      (i_rst_n),
    .i_look       ('{sector: i_req.sector, head: i_req.head,
                     drive: i_req.drive, cyl: i_req.cyl}),
    .o_hit        (c_hit),
    .o_hit_slot   (c_hit_slot),
    .i_touch      (c_touch),
    .i_touch_slot (c_hit_slot),
    .i_fill       (i_done_valid),
    .i_fill_tag   (i_done_tag),
    .o_fill_slot  (c_fill_slot)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    next_s           = s;
    mem_we           = 1'b0;
    mem_waddr        = '0;
    mem_wdata        = '0;
    mem_re           = 1'b0;
    mem_raddr        = '0;
    c_touch          = 1'b0;
    next_s.hit_valid = 1'b0;
    next_s.img_valid = i_done_valid; // R9
    if (i_done_valid) next_s.img_slot = c_fill_slot;
    unique case (s.st)
      DQS_IDLE: begin
        if (i_pop && s.head_valid) begin
          next_s.head_i     = s.head_i + 1'b1;
          next_s.qlen       = s.qlen - 1'b1;
          next_s.head_valid = 1'b0;
          next_s.st         = DQS_FETCH;
          next_s.ph         = '0;
          if (s.q1len != '0) next_s.q1len = s.q1len - 1'b1;
        end
        if (i_req_valid && s.req_ready) begin
          if (i_req.kind == DQS_READ && c_hit) begin
            next_s.hit_valid = 1'b1; // R10
            next_s.hit_slot  = c_hit_slot;
            c_touch          = 1'b1;
          end else begin
            next_s.newreq     = i_req;
            next_s.ins        = 1'b0;
            next_s.src_i      = next_s.head_i;
            next_s.dst_i      = '0;
            next_s.dst_q1     = '0;
            next_s.head_valid = 1'b0;
            next_s.st         = DQS_SCAN;
            next_s.ph         = '0;
          end
        end
      end
      DQS_FETCH: begin
        unique case (s.ph)
          2'h0: begin
            if (s.qlen == '0) begin
              next_s.st = DQS_IDLE;
            end else begin
              mem_re    = 1'b1;
              mem_raddr = ent_addr(s.bank, s.head_i, 1'b0);
              next_s.ph = 2'h1;
            end
          end
          2'h1: begin
            mem_re        = 1'b1;
            mem_raddr     = ent_addr(s.bank, s.head_i, 1'b1);
            next_s.hi_buf = mem_rdata;
            next_s.ph     = 2'h2;
          end
          2'h2: begin
            next_s.head       = rd_ent;
            next_s.head_valid = 1'b1;
            next_s.st         = DQS_IDLE;
            next_s.ph         = '0;
          end
          default: next_s.ph = '0;
        endcase
      end
      DQS_SCAN, DQS_MERGE: begin
        unique case (s.ph)
          2'h0: begin
            if (s.src_i == s.head_i + s.qlen) begin
              if (s.st == DQS_SCAN) begin
                next_s.src_i = s.head_i + s.q1len;
                next_s.st    = DQS_MERGE;
              end else if (!s.ins) begin
                next_s.em0 = new_ent; // R2
                next_s.em_n = 2'h1;
                next_s.ins  = 1'b1;
                next_s.ret  = DQS_MERGE;
                next_s.st   = DQS_EMIT;
              end else begin
                next_s.st = DQS_FIN;
              end
            end else begin
              mem_re    = 1'b1;
              mem_raddr = ent_addr(s.bank, s.src_i, 1'b0);
              next_s.ph = 2'h1;
            end
          end
          2'h1: begin
            mem_re        = 1'b1;
            mem_raddr     = ent_addr(s.bank, s.src_i, 1'b1);
            next_s.hi_buf = mem_rdata;
            next_s.ph     = 2'h2;
          end
          2'h2: begin
            next_s.ph    = '0;
            next_s.src_i = s.src_i + 1'b1;
            next_s.ret   = s.st;
            if (s.st == DQS_SCAN) begin
              if (s.src_i < s.head_i + s.q1len || rd_sat) begin
                next_s.em0    = rd_ent; // R5
                next_s.em_n   = 2'h1;
                next_s.dst_q1 = s.dst_q1 + 1'b1;
                next_s.st     = DQS_EMIT;
              end
            end else if (!rd_sat) begin
              next_s.st = DQS_EMIT;
              if (!s.ins && new_first) begin
                next_s.em0  = new_ent; // R3
                next_s.em1  = bumped_ent; // R6
                next_s.em_n = 2'h2;
                next_s.ins  = 1'b1;
              end else begin
                next_s.em0  = s.ins ? bumped_ent : rd_ent; // R6
                next_s.em_n = 2'h1;
              end
            end
          end
          default: next_s.ph = '0;
        endcase
      end
      DQS_EMIT: begin
        mem_we    = 1'b1; // R8
        mem_waddr = ent_addr(!s.bank, s.dst_i, s.ph[0]);
        mem_wdata = s.ph[0] ? em_word[MEM_W-1:0] : em_word[MEM_W +: MEM_W];
        next_s.ph = {1'b0, !s.ph[0]};
        if (s.ph[0]) begin
          next_s.dst_i = s.dst_i + 1'b1;
          next_s.em0   = s.em1;
          next_s.em_n  = s.em_n - 1'b1;
          if (s.em_n == 2'h1) next_s.st = s.ret;
        end
      end
      DQS_FIN: begin
        next_s.bank   = !s.bank;
        next_s.head_i = '0;
        next_s.qlen   = s.dst_i;
        next_s.q1len  = s.dst_q1; // R2
        next_s.st     = DQS_FETCH;
        next_s.ph     = '0;
      end
    endcase
    next_s.req_ready = next_s.st == DQS_IDLE && next_s.qlen < LW'(QD);
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign o_req_ready  = s.req_ready;
  assign o_hit_valid  = s.hit_valid;
  assign o_hit_slot   = s.hit_slot;
  assign o_head       = s.head;
  assign o_head_valid = s.head_valid;
  assign o_img_valid  = s.img_valid;
  assign o_img_slot   = s.img_slot;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  a_new_bump_zero: assert property ( // R1
    s.st == DQS_MERGE && s.ph == 2'h2 && !s.ins && !rd_sat && new_first
    |=> s.em0.bump == BUMP_ZERO && s.em1.req == $past(rd_ent.req))
    else $error("new request not started at zero");
  a_sat_to_prio: assert property ( // R5
    s.st == DQS_SCAN && s.ph == 2'h2 && rd_sat
    |=> s.st == DQS_EMIT && s.dst_q1 == $past(s.dst_q1) + 1'b1)
    else $error("saturated entry not moved to priority part");
  a_sat_skipped: assert property ( // R2
    s.st == DQS_MERGE && s.ph == 2'h2 && rd_sat
    |=> s.st == DQS_MERGE && s.ph == 2'h0 && s.dst_i == $past(s.dst_i))
    else $error("saturated entry copied into sorted part");
  a_bump_step: assert property ( // R6
    s.st == DQS_MERGE && s.ph == 2'h2 && s.ins && !rd_sat
    |=> s.em0.bump == $past(rd_ent.bump) + BUMP_STEP)
    else $error("entry behind new request not aged");
  a_sort_order: assert property ( // R3
    s.st == DQS_MERGE && s.ph == 2'h2 && !s.ins && !rd_sat && !new_first
    |=> !s.ins && s.em0 == $past(rd_ent))
    else $error("new request placed ahead of smaller key");
  a_write_first: assert property ( // R4
    s.st == DQS_MERGE && s.ph == 2'h2 && !s.ins && !rd_sat
    && s.newreq.kind == DQS_WRITE && rd_ent.req.kind == DQS_READ
    |=> s.em_n == 2'h2 && s.em0.req == $past(s.newreq))
    else $error("write not ordered before read");
  a_cyl_last: assert property ( // R11
    s.st == DQS_MERGE && s.ph == 2'h2 && !s.ins && !rd_sat
    && s.newreq.drive < rd_ent.req.drive
    && s.newreq[$bits(dqs_req_s)-1:DRV_W+CYL_W]
       == rd_ent.req[$bits(dqs_req_s)-1:DRV_W+CYL_W]
    |=> s.ins)
    else $error("cylinder outranked drive in ordering");
  a_hit_no_queue: assert property ( // R10
    i_req_valid && o_req_ready && i_req.kind == DQS_READ && c_hit
    |=> o_hit_valid && s.st != DQS_SCAN
    ##1 o_hit_valid == $past(i_req_valid && o_req_ready
      && i_req.kind == DQS_READ && c_hit))
    else $error("image hit was queued");
  a_miss_queued: assert property ( // R10
    i_req_valid && o_req_ready && !(i_req.kind == DQS_READ && c_hit)
    |=> s.st == DQS_SCAN && !o_req_ready)
    else $error("request neither served nor queued");
  a_img_report: assert property ( // R9
    i_done_valid |=> o_img_valid && o_img_slot == $past(c_fill_slot))
    else $error("retained image slot not reported");
  a_qlen_bound: assert property ( // R8
    s.qlen <= LW'(QD) && s.q1len <= s.qlen)
    else $error("queue exceeds buffer capacity");

  c_hit_served:  cover property (o_hit_valid);
  c_two_written: cover property (s.st == DQS_EMIT && s.em_n == 2'h2);
  c_sat_moved:   cover property (s.st == DQS_SCAN && s.ph == 2'h2 && rd_sat);
  c_popped:      cover property (i_pop && o_head_valid);
endmodule // dqs_sched

// File: dqs_host.sv
// Purpose: Host model offering requests to the scheduler
// Assumes: Lines change 1 ns after the rising edge
// Notes:   Released request lines show the inverse of the last value
`timescale 1ns/1ps
module dqs_host (
  // Clock and handshake
  input  wire logic                       i_clk,
  input  wire logic                       i_ready,
  // Request lines
  output logic                            o_valid,
  output dqs_pkg::dqs_req_s               o_req,
  output logic [dqs_pkg::BUMP_W-1:0]      o_limit
);
  import dqs_pkg::*;

  initial begin
    o_valid = 1'b0;
    o_req   = '0;
    o_limit = 4'hf;
  end

  // Only called while the queue is idle
  task automatic set_limit(input logic [BUMP_W-1:0] n);
    o_limit = n;
  endtask

  task automatic send(input dqs_req_s r);
    @(posedge i_clk);
    #1;
    o_valid = 1'b1;
    o_req   = r;
    // Ready is settled here and stands through the next edge
    while (i_ready !== 1'b1) begin
      @(posedge i_clk);
      #1;
    end
    @(posedge i_clk);
    #1;
    o_valid = 1'b0;
    o_req   = ~r;
  endtask
endmodule // dqs_host

// File: testbench.sv
// Purpose: Self-checking bench of the request queue scheduler
// Assumes: Queue depth 8; queue order mirrored by a small model
// Notes:   Inputs change 1 ns after the rising edge
`timescale 1ns/1ps
module testbench;
  import dqs_pkg::*;

  logic              i_clk;
  logic              i_rst_n;
  logic [BUMP_W-1:0] i_bump_limit;
  logic              i_req_valid;
  dqs_req_s          i_req;
  logic              o_req_ready;
  logic              o_hit_valid;
  logic [SLOT_W-1:0] o_hit_slot;
  logic              i_pop;
  dqs_ent_s          o_head;
  logic              o_head_valid;
  logic              i_done_valid;
  dqs_tag_s          i_done_tag;
  logic              o_img_valid;
  logic [SLOT_W-1:0] o_img_slot;
  int                num_errors = 0;
  int                tests_run  = 0;
  int                cyc        = 0;
  dqs_ent_s          pq[$];
  dqs_ent_s          sq[$];

  dqs_sched #(.QD(8)) u_dqs_sched (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_bump_limit(i_bump_limit),
    .i_req_valid(i_req_valid), .i_req(i_req), .o_req_ready(o_req_ready),
    .o_hit_valid(o_hit_valid), .o_hit_slot(o_hit_slot), .i_pop(i_pop),
    .o_head(o_head), .o_head_valid(o_head_valid),
    .i_done_valid(i_done_valid), .i_done_tag(i_done_tag),
    .o_img_valid(o_img_valid), .o_img_slot(o_img_slot));

  dqs_host u_dqs_host (
    .i_clk(i_clk), .i_ready(o_req_ready), .o_valid(i_req_valid),
    .o_req(i_req), .o_limit(i_bump_limit));

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end

  // ****************************************************************
  // Checks and reference queue
  // ****************************************************************
  task automatic chk_ent(input string nm, input dqs_ent_s e, g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_val(input string nm, input logic [3:0] e, g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic dqs_req_s mk(dqs_kind_e k, int s, int h, int d, int c);
    return '{k, SECT_W'(s), HEAD_W'(h), DRV_W'(d), CYL_W'(c)};
  endfunction

  function automatic dqs_tag_s tg(int s);
    return '{SECT_W'(s), HEAD_W'(0), DRV_W'(0), CYL_W'(0)};
  endfunction

  function automatic void m_ins(input dqs_req_s r);
    dqs_ent_s t[$];
    int       pos;
    pos = -1;
    foreach (sq[i]) begin
      if (sq[i].bump == i_bump_limit) pq.push_back(sq[i]);
      else t.push_back(sq[i]);
    end
    foreach (t[i]) if (pos < 0 && t[i].req > r) pos = i;
    if (pos < 0) pos = t.size();
    t.insert(pos, '{BUMP_ZERO, r});
    for (int i = pos + 1; i < t.size(); i++) t[i].bump += BUMP_STEP;
    sq = t;
  endfunction

  task automatic put(input dqs_req_s r);
    u_dqs_host.send(r);
    m_ins(r);
  endtask

  task automatic drain;
    dqs_ent_s e;
    while (pq.size() + sq.size() > 0) begin
      while (o_head_valid !== 1'b1) begin
        @(posedge i_clk);
        #1;
      end
      e = (pq.size() > 0) ? pq.pop_front() : sq.pop_front();
      chk_ent("head", e, o_head);
      i_pop = 1'b1;
      @(posedge i_clk);
      #1;
      i_pop = 1'b0;
    end
    repeat (8) @(posedge i_clk);
    #1;
    chk_val("head_valid", 4'h0, {3'h0, o_head_valid});
  endtask

  task automatic fill(input dqs_tag_s t, input logic [2:0] s);
    @(posedge i_clk);
    #1;
    i_done_valid = 1'b1;
    i_done_tag   = t;
    @(posedge i_clk);
    #1;
    i_done_valid = 1'b0;
    i_done_tag   = ~t;
    chk_val("img_valid", 4'h1, {3'h0, o_img_valid});
    chk_val("img_slot", {1'b0, s}, {1'b0, o_img_slot});
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_sort;
    u_dqs_host.set_limit(4'hf);
    put(mk(DQS_READ, 5, 0, 0, 1));
    put(mk(DQS_WRITE, 5, 0, 0, 1));
    put(mk(DQS_READ, 2, 3, 0, 0));
    put(mk(DQS_READ, 2, 1, 0, 0));
    put(mk(DQS_READ, 2, 1, 2, 0));
    put(mk(DQS_READ, 2, 1, 1, 9));
    put(mk(DQS_READ, 2, 1, 1, 3));
    put(mk(DQS_WRITE, 5, 0, 0, 1));
    drain();
  endtask

  task automatic t_age;
    u_dqs_host.set_limit(4'h2);
    for (int i = 9; i > 2; i--) put(mk(DQS_WRITE, i, 0, 0, 0));
    drain();
    u_dqs_host.set_limit(4'h0);
    for (int i = 3; i > 0; i--) put(mk(DQS_WRITE, i, 0, 0, 0));
    drain();
  endtask

  task automatic t_img;
    for (int k = 0; k < 8; k++) fill(tg(k + 20), 3'(7 - k));
    fill(tg(20), 3'h7);
    u_dqs_host.send(mk(DQS_READ, 24, 0, 0, 0));
    chk_val("hit_valid", 4'h1, {3'h0, o_hit_valid});
    chk_val("hit_slot", 4'h3, {1'b0, o_hit_slot});
    fill(tg(40), 3'h6);
    put(mk(DQS_WRITE, 24, 0, 0, 0));
    chk_val("hit_valid", 4'h0, {3'h0, o_hit_valid});
    drain();
  endtask

  task automatic report_and_stop;
    if (num_errors == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    i_rst_n      = 1'b0;
    i_pop        = 1'b0;
    i_done_valid = 1'b0;
    i_done_tag   = '0;
    repeat (2) @(posedge i_clk);
    #1;
    chk_val("ready_rst", 4'h0, {3'h0, o_req_ready});
    chk_val("head_rst", 4'h0, {3'h0, o_head_valid});
    i_rst_n = 1'b1;
    t_sort();
    t_age();
    t_img();
    report_and_stop();
  end
endmodule // testbench
